//--- cpu_interrupt_flag_control.sv
// Interrupt enable, stack select and priority level flag logic
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_flag_control
    import flag_ctrl_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [DATA_W-1:0] reg_rdata_out,
    // Interrupt sources
    input wire irq_req_t irq_req_in,
    input wire logic nmi_req_in,
    // Sequencer
    input wire logic ack_in,
    input wire trap_req_t trap_in,
    input wire logic [PRIO_W-1:0] ret_prio_in,
    input wire logic ret_irq_en_in,
    input wire logic ret_stack_sel_in,
    input wire logic ret_in,
    // Flags toward the core
    output logic irq_accept_out,
    output logic nmi_accept_out,
    output logic [PRIO_W-1:0] ack_prio_out,
    output logic irq_en_out,
    output logic use_user_stack_out,
    output logic [PRIO_W-1:0] cpu_priority_level_out
);
    // ****************************************************************
    // Flag storage and decode nets
    // ****************************************************************
    logic irq_en_ff;
    logic stack_sel_ff;
    logic rsvd_ff;
    logic [PRIO_W-1:0] cpu_priority_level_ff;
    logic nxt_irq_en;
    logic nxt_stack_sel;
    logic nxt_rsvd;
    logic [PRIO_W-1:0] nxt_cpu_priority_level;
    logic nxt_irq_accept;
    logic nxt_nmi_accept;
    logic [PRIO_W-1:0] nxt_ack_prio;
    logic [DATA_W-1:0] nxt_reg_rdata;
    logic [DATA_W-1:0] flag_word;
    logic [DATA_W-1:0] status_word;
    logic irq_pending;
    logic prio_above;
    logic irq_ok;
    logic any_offer;
    logic hw_ack;
    logic irq_taken;
    logic trap_hit;
    logic trap_low;
    logic flag_wr;
    logic flag_rd;
    logic status_rd;

    // ****************************************************************
    // Request and event decode
    // ****************************************************************

    // Maskable request: pending, above the level and not gated off
    assign irq_pending = irq_req_in.valid;
    assign prio_above = irq_req_in.prio > cpu_priority_level_ff;
    assign irq_ok = irq_pending && irq_en_ff
        && prio_above;

    // Sequencer take of whichever offer stands this cycle
    assign any_offer = irq_accept_out || nmi_accept_out;
    assign hw_ack = ack_in && any_offer;
    assign irq_taken = ack_in && irq_accept_out;

    // Software traps; low numbers also drop to the supervisor stack
    assign trap_hit = trap_in.valid;
    assign trap_low = trap_hit && (trap_in.num <= TRAP_STACK_MAX);

    // Register strobes qualified by address
    assign flag_wr = reg_wr_in && (reg_addr_in == FLAG_REG_ADDR);
    assign flag_rd = reg_rd_in && (reg_addr_in == FLAG_REG_ADDR);
    assign status_rd = reg_rd_in && (reg_addr_in == STATUS_REG_ADDR);

    // ****************************************************************
    // Interrupt enable flag
    // ****************************************************************

    // Acknowledge or trap wins over a restore and a software write
    always_comb begin
        nxt_irq_en = irq_en_ff;
        if (hw_ack || trap_hit) begin
            nxt_irq_en = 1'b0;
        end else if (ret_in) begin
            nxt_irq_en = ret_irq_en_in;
        end else if (flag_wr) begin
            nxt_irq_en = reg_wdata_in[IRQ_EN_POS];
        end
    end

    // Enable flag register
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_en_ff <= RESET_IRQ_EN;
        end else begin
            irq_en_ff <= nxt_irq_en;
        end
    end

    // ****************************************************************
    // Stack select flag
    // ****************************************************************

    // Hardware take or low trap forces the supervisor stack
    always_comb begin
        nxt_stack_sel = stack_sel_ff;
        if (hw_ack || trap_low) begin
            nxt_stack_sel = 1'b0;
        end else if (ret_in) begin
            nxt_stack_sel = ret_stack_sel_in;
        end else if (flag_wr) begin
            nxt_stack_sel = reg_wdata_in[STACK_SEL_POS];
        end
    end

    // Stack select register
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stack_sel_ff <= RESET_STACK_SEL;
        end else begin
            stack_sel_ff <= nxt_stack_sel;
        end
    end

    // ****************************************************************
    // Processor priority level
    // ****************************************************************

    // Raised to the level of the maskable request being taken
    always_comb begin
        nxt_cpu_priority_level = cpu_priority_level_ff;
        if (irq_taken) begin
            nxt_cpu_priority_level = ack_prio_out;
        end else if (ret_in) begin
            nxt_cpu_priority_level = ret_prio_in;
        end else if (flag_wr) begin
            nxt_cpu_priority_level = reg_wdata_in[PRIO_LSB +: PRIO_W];
        end
    end

    // Priority level register, eight levels in three bits
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cpu_priority_level_ff <= RESET_PRIO;
        end else begin
            cpu_priority_level_ff <= nxt_cpu_priority_level;
        end
    end

    // ****************************************************************
    // Reserved bit
    // ****************************************************************

    // Keeps the last written value; software must not rely on it
    always_comb begin
        nxt_rsvd = rsvd_ff;
        if (flag_wr) begin
            nxt_rsvd = reg_wdata_in[RSVD_POS];
        end
    end

    // Reserved bit register
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rsvd_ff <= 1'b0;
        end else begin
            rsvd_ff <= nxt_rsvd;
        end
    end

    // ****************************************************************
    // Acceptance offer to the sequencer
    // ****************************************************************

    // Offer drops while the current one is taken or a trap runs
    always_comb begin
        nxt_irq_accept = 1'b0;
        nxt_nmi_accept = 1'b0;
        nxt_ack_prio = ack_prio_out;
        if (!(hw_ack || trap_hit)) begin
            nxt_nmi_accept = nmi_req_in;
            nxt_irq_accept = irq_ok && !nmi_req_in;
            nxt_ack_prio = irq_req_in.prio;
        end
    end

    // Maskable offer, yields to a pending non-maskable request
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_accept_out <= 1'b0;
        end else begin
            irq_accept_out <= nxt_irq_accept;
        end
    end

    // Non-maskable offer, never gated by enable or level
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            nmi_accept_out <= 1'b0;
        end else begin
            nmi_accept_out <= nxt_nmi_accept;
        end
    end

    // Priority carried with the offer, held while it is taken
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ack_prio_out <= RESET_PRIO;
        end else begin
            ack_prio_out <= nxt_ack_prio;
        end
    end

    // ****************************************************************
    // Mirrored flag outputs
    // ****************************************************************

    // Enable flag toward the core
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_en_out <= RESET_IRQ_EN;
        end else begin
            irq_en_out <= irq_en_ff;
        end
    end

    // Stack choice: supervisor pointer at 0, user pointer at 1
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            use_user_stack_out <= RESET_STACK_SEL;
        end else begin
            use_user_stack_out <= stack_sel_ff;
        end
    end

    // Priority level toward the core
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cpu_priority_level_out <= RESET_PRIO;
        end else begin
            cpu_priority_level_out <= cpu_priority_level_ff;
        end
    end

    // ****************************************************************
    // Register read port
    // ****************************************************************

    // Flag register image
    always_comb begin
        flag_word = '0;
        flag_word[IRQ_EN_POS] = irq_en_ff;
        flag_word[STACK_SEL_POS] = stack_sel_ff;
        flag_word[RSVD_POS] = rsvd_ff;
        flag_word[PRIO_LSB +: PRIO_W] = cpu_priority_level_ff;
    end

    // Status register image, read only
    always_comb begin
        status_word = '0;
        status_word[STS_PEND_POS] = irq_req_in.valid;
        status_word[STS_ACCEPT_POS] = irq_accept_out;
        status_word[STS_PRIO_LSB +: PRIO_W] = irq_req_in.prio;
    end

    // Read select; unmapped or idle cycles give zero
    always_comb begin
        nxt_reg_rdata = '0;
        if (flag_rd) begin
            nxt_reg_rdata = flag_word;
        end else if (status_rd) begin
            nxt_reg_rdata = status_word;
        end
    end

    // Read data stands for the single cycle after the strobe
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= '0;
        end else begin
            reg_rdata_out <= nxt_reg_rdata;
        end
    end
endmodule
`default_nettype wire

//--- flag_ctrl_chk.sv
// Checker for the interrupt flag control block
`timescale 1ns/1ps
`default_nettype none
module flag_ctrl_chk
    import flag_ctrl_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire irq_req_t irq_req_in,
    input wire logic nmi_req_in,
    input wire logic ack_in,
    input wire trap_req_t trap_in,
    input wire logic irq_accept_out,
    input wire logic nmi_accept_out,
    input wire logic [PRIO_W-1:0] ack_prio_out,
    input wire logic irq_en_out,
    input wire logic use_user_stack_out,
    input wire logic [PRIO_W-1:0] cpu_priority_level_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    // Acknowledge of an offer, trap classes, plain maskable request
    wire take = ack_in && (irq_accept_out || nmi_accept_out);
    wire lo_trap = trap_in.valid && trap_in.num <= TRAP_STACK_MAX;
    wire hi_trap = trap_in.valid && trap_in.num > TRAP_STACK_MAX;
    wire plain = irq_req_in.valid && !nmi_req_in && !ack_in && !trap_in.valid;
    a_accept_en: assert property (irq_accept_out |-> irq_en_out)
        else $error("accept while off");
    a_accept_prio: assert property (
        irq_accept_out |-> ack_prio_out > cpu_priority_level_out)
        else $error("accept at low prio");
    a_accept_both: assert property (
        $past(plain) && irq_en_out &&
        $past(irq_req_in.prio) > cpu_priority_level_out |-> irq_accept_out)
        else $error("accept missing");
    a_ack_en: assert property (take |-> ##2 !irq_en_out)
        else $error("enable kept");
    a_ack_stack: assert property (take |-> ##2 !use_user_stack_out)
        else $error("stack kept");
    a_trap_lo: assert property (lo_trap |-> ##2 !use_user_stack_out)
        else $error("trap stack kept");
    a_trap_hi: assert property (
        hi_trap && !take |-> ##2 $stable(use_user_stack_out))
        else $error("trap stack moved");
    a_ack_level: assert property (
        take && irq_accept_out |->
        ##2 cpu_priority_level_out == $past(ack_prio_out, 2))
        else $error("level wrong");
    c_irq: cover property (take && irq_accept_out);
    c_nmi: cover property (take && nmi_accept_out);
    c_hi: cover property (hi_trap);
endmodule
bind cpu_interrupt_flag_control flag_ctrl_chk u_flag_ctrl_chk (.*);
`default_nettype wire

//--- flag_ctrl_pkg.sv
// Package for the processor interrupt flag control block
package flag_ctrl_pkg;
    localparam int PRIO_W = 3;
    localparam int TRAP_W = 6;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    // Register offsets
    localparam logic [ADDR_W-1:0] FLAG_REG_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_REG_ADDR = 4'h1;
    // Field positions in the flag register
    localparam int IRQ_EN_POS = 0;
    localparam int STACK_SEL_POS = 1;
    localparam int RSVD_POS = 2;
    localparam int PRIO_LSB = 4;
    // Field positions in the status register
    localparam int STS_PEND_POS = 0;
    localparam int STS_ACCEPT_POS = 1;
    localparam int STS_PRIO_LSB = 4;
    // Reset values
    localparam logic RESET_IRQ_EN = 1'b0;
    localparam logic RESET_STACK_SEL = 1'b0;
    localparam logic [PRIO_W-1:0] RESET_PRIO = 3'h0;
    // Trap numbers at or below this clear the stack select flag
    localparam logic [TRAP_W-1:0] TRAP_STACK_MAX = 6'h1f;
    // Maskable request from the interrupt sources
    typedef struct packed {
        logic valid;
        logic [PRIO_W-1:0] prio;
    } irq_req_t;
    // Software trap from the instruction sequencer
    typedef struct packed {
        logic valid;
        logic [TRAP_W-1:0] num;
    } trap_req_t;
    typedef enum logic [1:0] {ST_IDLE, ST_OFFER, ST_WAIT} acc_state_t;
endpackage

//--- flag_ctrl_seq_model.sv
// Sequencer model that acknowledges offered interrupts
`timescale 1ns/1ps
`default_nettype none
module flag_ctrl_seq_model (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic offer_in,
    output logic ack_out
);
    // One-cycle acknowledge after an offer is seen
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ack_out <= 1'b0;
        end else begin
            ack_out <= offer_in && !ack_out;
        end
    end
endmodule
`default_nettype wire

//--- test_cpu_interrupt_flag_control.sv
// Testbench for the interrupt flag control block
`timescale 1ns/1ps
`default_nettype none
module test_cpu_interrupt_flag_control;
    import flag_ctrl_pkg::*;
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [ADDR_W-1:0] reg_addr_in = '0;
    logic [DATA_W-1:0] reg_wdata_in = '0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [DATA_W-1:0] reg_rdata_out;
    irq_req_t irq_req_in = '0;
    logic nmi_req_in = 1'b0;
    logic ack_in;
    trap_req_t trap_in = '0;
    logic [PRIO_W-1:0] ret_prio_in = 3'h2;
    logic ret_irq_en_in = 1'b1;
    logic ret_stack_sel_in = 1'b1;
    logic ret_in = 1'b0;
    logic irq_accept_out;
    logic nmi_accept_out;
    logic [PRIO_W-1:0] ack_prio_out;
    logic irq_en_out;
    logic use_user_stack_out;
    logic [PRIO_W-1:0] cpu_priority_level_out;
    logic [TRAP_W-1:0] tnum [4] = '{6'h00, 6'h1f, 6'h20, 6'h3f};
    logic [DATA_W-1:0] texp [4] = '{16'h0000, 16'h0000, 16'h0002, 16'h0002};
    int miscompares = 0;
    int num_checks = 0;
    // Clock and design instances
    always #2.5 clk_sys_in = ~clk_sys_in;
    cpu_interrupt_flag_control u_cpu_interrupt_flag_control (.*);
    flag_ctrl_seq_model u_flag_ctrl_seq_model (.clk_sys_in, .reset_n_in,
        .offer_in(irq_accept_out || nmi_accept_out), .ack_out(ack_in));
    task automatic chk(input logic [DATA_W-1:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        @(posedge clk_sys_in);
        chk(reg_rdata_out, e);
    endtask
    task automatic wait_ack();
        for (int i = 0; i < 20; i++) begin
            @(posedge clk_sys_in);
            if (ack_in === 1'b1) begin
                irq_req_in <= '0;
                nmi_req_in <= 1'b0;
                return;
            end
        end
        miscompares++;
        end_of_test();
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        rd(FLAG_REG_ADDR, 16'h0000);
        wr(FLAG_REG_ADDR, 16'h0033);
        rd(FLAG_REG_ADDR, 16'h0033);
        chk(use_user_stack_out, 16'h0001);
        irq_req_in <= '{1'b1, 3'h3};
        repeat (4) @(posedge clk_sys_in);
        chk(irq_accept_out, 16'h0000);
        rd(STATUS_REG_ADDR, 16'h0031);
        irq_req_in <= '{1'b1, 3'h4};
        wait_ack();
        rd(FLAG_REG_ADDR, 16'h0040);
        irq_req_in <= '{1'b1, 3'h7};
        repeat (4) @(posedge clk_sys_in);
        chk(irq_accept_out, 16'h0000);
        rd(STATUS_REG_ADDR, 16'h0071);
        irq_req_in <= '0;
        ret_in <= 1'b1;
        @(posedge clk_sys_in);
        ret_in <= 1'b0;
        rd(FLAG_REG_ADDR, 16'h0023);
        rd(4'h5, 16'h0000);
        $display("accept test done");
        for (int i = 0; i < 4; i++) begin
            wr(FLAG_REG_ADDR, 16'h0003);
            trap_in <= '{1'b1, tnum[i]};
            @(posedge clk_sys_in);
            trap_in <= '0;
            rd(FLAG_REG_ADDR, texp[i]);
        end
        $display("trap test done");
        wr(FLAG_REG_ADDR, 16'h0073);
        nmi_req_in <= 1'b1;
        wait_ack();
        rd(FLAG_REG_ADDR, 16'h0070);
        $display("nmi test done");
        end_of_test();
    end
endmodule
`default_nettype wire
